/* inc/atsm_pkg.sv */
// package of constants for the ata status timeout monitor
package atsm_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DEVCTL = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_INTST  = 8'h10;
  localparam logic [7:0] OFS_INTMSK = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SRST_BIT = 2;
  localparam int BSY_BIT  = 7;
  localparam int RDY_BIT  = 6;
  localparam int DRQ_BIT  = 3;
  localparam int ERR_BIT  = 0;
  localparam int CAT_LSB  = 8;
  localparam int EV_DRQ   = 0;
  localparam int EV_DONE  = 1;
  localparam int EV_RST   = 2;
  localparam int EV_TMO   = 3;
  localparam int NEV      = 4;
  // ----------------------------------------------------------------
  // command categories and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CAT_DIN  = 2'h0;
  localparam logic [1:0] CAT_DOUT = 2'h1;
  localparam logic [1:0] CAT_ND   = 2'h2;
  localparam logic [1:0] CAT_DMA  = 2'h3;
  localparam logic [NEV-1:0] MSK_RST = 4'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 20;
  localparam int BSY_NS    = 400;
  localparam int DIN_US    = 10;
  localparam int DOUT_US   = 5;
  localparam int READY_S   = 31;
  localparam int CMD_S     = 30;
  localparam int WORDS     = 256;
  localparam int BSY_CYC   = (BSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIN_CYC   = DIN_US * 1000 / CLK_NS;
  localparam int DOUT_CYC  = DOUT_US * 1000 / CLK_NS;
  localparam longint READY_CYC = longint'(READY_S) * 1000000000 / CLK_NS;
  localparam longint CMD_CYC   = longint'(CMD_S) * 1000000000 / CLK_NS;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SRST, ST_RECOV, ST_HRST, ST_BUSY, ST_DIN, ST_DOUT
  } atsm_state_t;
endpackage

/* src/atsm_top.sv */
// task-file status sequencer with busy, ready and drq time limits
//
// Operation
// RULE_01: setting soft reset bit shows busy within 400 ns.
// RULE_02: soft reset release ends in ready, not busy, within 31 s.
// RULE_03: bus reset shows busy within 400 ns, ready within 31 s.
// RULE_04: any command register write shows busy within 400 ns; the code takes the write only in idle and ignores it during drq.
// RULE_05: data-in command reaches drq with interrupt within 30 s.
// RULE_06: data-in shows busy within 10 us of 256th data read.
// RULE_07: data-out shows busy within 5 us of 256th data write.
// RULE_08: host on timeout should soft reset and retry the command.
// RULE_09: host times every interval separately and flags expiry.
`timescale 1ns/10ps
`default_nettype none
module atsm_top
  import atsm_pkg::*;
#(
  parameter int unsigned READY_CYCLES = 32'(READY_CYC),
  parameter int unsigned CMD_CYCLES   = 32'(CMD_CYC)
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // bus reset pin
  input  wire logic        ata_reset_n,
  // drive back end
  input  wire logic        be_ready,
  input  wire logic        be_xfer,
  input  wire logic        be_done,
  input  wire logic [15:0] be_rdata,
  output var  logic        be_reset,
  output var  logic        be_cmd_stb,
  output var  logic [9:0]  be_cmd,
  output var  logic        be_rd_stb,
  output var  logic        be_wr_stb,
  output var  logic [15:0] be_wdata,
  // status
  output var  logic        bsy,
  output var  logic        rdy,
  output var  logic        drq,
  output var  logic        irq
);
  // the timer needs at least one count below its load value
  if (READY_CYCLES < 2 || CMD_CYCLES < 2)
  begin : g_bad_limits
    $error("atsm_top: time limits too short");
  end
  // ----------------------------------------------------------------
  // bus reset synchroniser
  // ----------------------------------------------------------------
  logic hr_meta;
  logic hr_sync;
  logic hr_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hr_meta <= 1'b0;
      hr_sync <= 1'b0;
      hr_q    <= 1'b0;
    end
    else
    begin
      hr_meta <= ~ata_reset_n;
      hr_sync <= hr_meta;
      hr_q    <= hr_sync;
    end
  end
  wire hr_edge = hr_sync & ~hr_q;
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc     = psel & penable & pready;
  wire wr      = acc & pwrite;
  wire rd      = acc & ~pwrite;
  wire a_dev   = paddr == OFS_DEVCTL;
  wire a_cmd   = paddr == OFS_CMD;
  wire a_data  = paddr == OFS_DATA;
  wire a_stat  = paddr == OFS_STAT;
  wire a_ist   = paddr == OFS_INTST;
  wire a_msk   = paddr == OFS_INTMSK;
  wire a_ok    = a_dev | a_cmd | a_data | a_stat | a_ist | a_msk;
  // ----------------------------------------------------------------
  // state and next-state logic
  // ----------------------------------------------------------------
  atsm_state_t state;
  atsm_state_t next_state;
  logic             srst;
  logic [9:0]       cmd;
  logic [7:0]       wcnt;
  logic [31:0]      tmr;
  logic             err;
  logic [NEV-1:0]   ist;
  logic [NEV-1:0]   msk;
  logic             load;
  logic [31:0]      lim;
  logic [NEV-1:0]   ev;
  wire tmo     = tmr == 32'h0;
  wire cmd_wr  = wr & a_cmd & (state == ST_IDLE);
  wire dat_rd  = rd & a_data & (state == ST_DIN);
  wire dat_wr  = wr & a_data & (state == ST_DOUT);
  wire last_w  = wcnt == 8'(WORDS - 1);
  wire [1:0] cat = cmd[CAT_LSB+1:CAT_LSB];
  always_comb
  begin
    next_state = state;
    load       = 1'b0;
    lim        = READY_CYCLES - 32'h1;
    ev         = '0;
    if (hr_edge)
    begin
      next_state = ST_HRST; // see RULE_03
      load       = 1'b1;
    end
    else if (hr_sync)
      next_state = ST_HRST;
    else if (srst)
      next_state = ST_SRST; // see RULE_01
    else
      case (state)
        ST_SRST:
        begin
          next_state = ST_RECOV; // see RULE_02
          load       = 1'b1;
        end
        ST_RECOV, ST_HRST:
          if (be_ready || tmo)
          begin
            next_state = ST_IDLE; // see RULE_02
            ev[EV_RST] = 1'b1;
          end
        ST_IDLE:
          if (cmd_wr)
          begin
            next_state = ST_BUSY; // see RULE_04
            load       = 1'b1;
            lim        = CMD_CYCLES - 32'h1;
          end
        ST_BUSY:
          if (be_done)
          begin
            next_state  = ST_IDLE;
            ev[EV_DONE] = 1'b1;
          end
          else if (be_xfer && cat == CAT_DIN)
          begin
            next_state = ST_DIN; // see RULE_05
            ev[EV_DRQ] = 1'b1;
          end
          else if (be_xfer && cat == CAT_DOUT)
            next_state = ST_DOUT;
          else if (tmo)
          begin
            // a stuck back end still ends the command, with error
            next_state = ST_IDLE; // see RULE_05
            ev[EV_TMO] = 1'b1;
          end
        ST_DIN:
          if (dat_rd && last_w)
          begin
            next_state = ST_BUSY; // see RULE_06
            load       = 1'b1;
            lim        = CMD_CYCLES - 32'h1;
          end
        ST_DOUT:
          if (dat_wr && last_w)
          begin
            next_state = ST_BUSY; // see RULE_07
            load       = 1'b1;
            lim        = CMD_CYCLES - 32'h1;
          end
        default:
          next_state = ST_IDLE;
      endcase
  end
  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  wire next_idle = next_state == ST_IDLE;
  wire next_drq  = (next_state == ST_DIN) | (next_state == ST_DOUT);
  wire [NEV-1:0] next_ist = ev | (ist & ~((wr & a_ist) ? pwdata[NEV-1:0]
                                                        : {NEV{1'b0}}));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      tmr   <= 32'h0;
      wcnt  <= 8'h0;
      bsy   <= 1'b0;
      rdy   <= 1'b1;
      drq   <= 1'b0;
      ist   <= '0;
      irq   <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr   <= load ? lim : (tmo ? tmr : tmr - 32'h1);
      wcnt  <= (dat_rd | dat_wr) ? wcnt + 8'h1 : (next_drq ? wcnt : 8'h0);
      bsy   <= ~next_idle & ~next_drq;
      rdy   <= next_idle | next_drq;
      drq   <= next_drq;
      ist   <= next_ist; // set wins over clear
      irq   <= |(next_ist & msk);
    end
  end
  // ----------------------------------------------------------------
  // software registers and back-end strobes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      srst       <= 1'b0;
      cmd        <= 10'h000;
      err        <= 1'b0;
      msk        <= MSK_RST;
      be_reset   <= 1'b0;
      be_cmd_stb <= 1'b0;
      be_cmd     <= 10'h000;
      be_rd_stb  <= 1'b0;
      be_wr_stb  <= 1'b0;
      be_wdata   <= 16'h0000;
    end
    else
    begin
      if (wr && a_dev)
        srst <= pwdata[SRST_BIT];
      if (cmd_wr)
        cmd <= pwdata[9:0];
      if (ev[EV_TMO])
        err <= 1'b1;
      else if (cmd_wr)
        err <= 1'b0;
      if (wr && a_msk)
        msk <= pwdata[NEV-1:0];
      // back end let go once the pin releases, so it can report ready
      be_reset   <= (next_state == ST_SRST) | hr_sync;
      be_cmd_stb <= cmd_wr;
      be_cmd     <= cmd_wr ? pwdata[9:0] : be_cmd;
      be_rd_stb  <= dat_rd;
      be_wr_stb  <= dat_wr;
      be_wdata   <= dat_wr ? pwdata[15:0] : be_wdata;
    end
  end
  // ----------------------------------------------------------------
  // apb answer, registered in setup, no wait state
  // ----------------------------------------------------------------
  wire [31:0] stat_w = {24'h0, bsy, rdy, 2'h0, drq, 2'h0, err};
  wire [31:0] rd_mux = a_dev  ? {29'h0, srst, 2'h0} :
                       a_cmd  ? {22'h0, cmd} :
                       a_data ? ((state == ST_DIN) ? {16'h0, be_rdata}
                                                   : 32'h0) :
                       a_stat ? stat_w :
                       a_ist  ? {28'h0, ist} :
                       a_msk  ? {28'h0, msk} : 32'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable & ~pready;
      prdata  <= (psel & ~penable) ? rd_mux : 32'h0;
      pslverr <= psel & ~penable & ~a_ok;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int LIM_BSY  = BSY_CYC;
  localparam int LIM_DOUT = DOUT_CYC;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_SRST_BSY: assert property ( // see RULE_01
    wr && a_dev && pwdata[SRST_BIT] |-> ##[1:LIM_BSY] bsy)
    else $error("busy late after soft reset");
  AST_SRST_RDY: assert property ( // see RULE_02
    state == ST_RECOV && !hr_sync && !srst && (be_ready || tmo)
      |=> rdy && !bsy)
    else $error("ready late after soft reset release");
  AST_HRST_BSY: assert property ( // see RULE_03
    $fell(ata_reset_n) && !srst |-> ##[1:LIM_BSY] bsy)
    else $error("busy late after bus reset");
  AST_HRST_HOLD: assert property ( // see RULE_03
    hr_sync |=> bsy && !rdy)
    else $error("not busy while bus reset held");
  AST_CMD_BSY: assert property ( // see RULE_04
    cmd_wr && !hr_sync && !srst |-> ##[1:LIM_BSY] bsy && !drq)
    else $error("busy late after command write");
  AST_DIN_IRQ: assert property ( // see RULE_05
    ev[EV_DRQ] && msk[EV_DRQ] |=> irq && drq && !bsy)
    else $error("drq without interrupt on data-in");
  AST_DIN_BSY: assert property ( // see RULE_06
    dat_rd && last_w && !hr_sync && !srst |=> bsy && !drq)
    else $error("busy late after last data read");
  AST_DOUT_BSY: assert property ( // see RULE_07
    dat_wr && last_w |-> ##[1:LIM_DOUT] bsy)
    else $error("busy late after last data write");
  AST_DRQ_EXCL: assert property (
    drq |-> !bsy && rdy)
    else $error("drq with busy");
  COV_SRST: cover property (state == ST_RECOV ##1 state == ST_IDLE);
  COV_DIN: cover property (state == ST_DIN ##1 state == ST_BUSY);
  COV_DOUT: cover property (state == ST_DOUT ##1 state == ST_BUSY);
  COV_TMO: cover property (ev[EV_TMO]);
endmodule // atsm_top
`default_nettype wire

/* verification/atsm_be_model.sv */
// back-end model facing the status sequencer
`timescale 1ns/10ps
`default_nettype none
module atsm_be_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench control
  input  wire logic [7:0]  dly,
  input  wire logic        done_req,
  // sequencer side
  input  wire logic        be_reset,
  input  wire logic        be_cmd_stb,
  input  wire logic [9:0]  be_cmd,
  output var  logic        be_ready,
  output var  logic        be_xfer,
  output var  logic        be_done,
  output var  logic [15:0] be_rdata
);
  // ----------------------------------------------------------------
  // responses
  // ----------------------------------------------------------------
  logic [7:0] rc;
  logic [7:0] xc;
  // dly of zero never raises ready or xfer, so the sequencer's own limits must act
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rc       <= 8'h0;
      xc       <= 8'h0;
      be_ready <= 1'h0;
      be_xfer  <= 1'h0;
      be_done  <= 1'h0;
      be_rdata <= 16'h0;
    end
    else
    begin
      // recovery is counted from the release of reset
      rc       <= be_reset ? 8'h0 : (rc != 8'hFF ? rc + 8'h1 : rc);
      be_ready <= !be_reset && dly != 8'h0 && rc == dly;
      xc       <= (be_cmd_stb && !be_cmd[9]) ? dly :
                  (xc != 8'h0 ? xc - 8'h1 : xc);
      be_xfer  <= xc == 8'h1;
      be_done  <= done_req;
      // read data wanders each cycle, never a stale value
      be_rdata <= be_rdata + 16'h1;
    end
endmodule // atsm_be_model
`default_nettype wire

/* verification/atsm_bench.sv */
// self-checking bench of the status sequencer
`timescale 1ns/10ps
`default_nettype none
module atsm_bench;
  import atsm_pkg::*;
  localparam int R = 200;
  localparam int C = 300;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        ata_reset_n, done_req, be_ready, be_xfer, be_done, be_reset;
  logic        be_cmd_stb, be_rd_stb, be_wr_stb, bsy, rdy, drq, irq;
  logic [7:0]  paddr, dly;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] be_rdata, be_wdata;
  logic [9:0]  be_cmd;
  int          errors, samples_checked, cyc, n, t, nr, nw;
  wire  [3:0]  st = {bsy, rdy, drq, irq};
  atsm_top #(.READY_CYCLES(R), .CMD_CYCLES(C)) i_atsm_top (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ata_reset_n, .be_ready, .be_xfer, .be_done, .be_rdata, .be_reset,
    .be_cmd_stb, .be_cmd, .be_rd_stb, .be_wr_stb, .be_wdata, .bsy, .rdy,
    .drq, .irq);
  atsm_be_model i_atsm_be_model (.pclk, .presetn, .dly, .done_req,
    .be_reset, .be_cmd_stb, .be_cmd, .be_ready, .be_xfer, .be_done,
    .be_rdata);
  // ----------------------------------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    nr += int'(be_rd_stb === 1'h1);
    nw += int'(be_wr_stb === 1'h1);
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  // host timer of one interval, edges counted until the level shows
  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (st[b] !== v && n <= lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic issue(input logic [1:0] c);
    apb(1'h1, OFS_CMD, {22'h0, c, 8'hA5});
    wt(3, 1'h1, BSY_CYC);
    chk(n <= BSY_CYC, 1, "cmd bsy");
    chk(be_cmd, {c, 8'hA5}, "cmd code");
  endtask
  task automatic fin(input logic ei);
    done_req <= 1'h1;
    @(posedge pclk);
    done_req <= 1'h0;
    wt(3, 1'h0, 4);
    apb(1'h0, OFS_INTST, 32'h0);
    chk({rdy, rd[EV_DONE], irq}, {2'h3, ei}, "done");
    apb(1'h1, OFS_INTST, 32'hF);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'h0, OFS_STAT, 32'h0);
    chk(rd, 32'h40, "status");
    apb(1'h0, OFS_INTMSK, 32'h0);
    chk(rd, 32'(MSK_RST), "mask");
    apb(1'h0, 8'h18, 32'h0);
    chk(e, 1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("regs done");
  endtask
  task automatic t_srst(input logic [7:0] d);
    dly <= d;
    apb(1'h1, OFS_DEVCTL, 32'h4);
    wt(3, 1'h1, BSY_CYC);
    chk(n <= BSY_CYC, 1, "srst bsy");
    chk(be_reset, 1, "be reset");
    apb(1'h1, OFS_DEVCTL, 32'h0);
    wt(3, 1'h0, R + 2);
    chk({n <= R + 2, rdy}, 2'h3, "srst rdy");
    apb(1'h0, OFS_INTST, 32'h0);
    chk(rd[EV_RST], 1, "rst ev");
    apb(1'h1, OFS_INTST, 32'hF);
    apb(1'h0, OFS_INTST, 32'h0);
    chk(rd, 32'h0, "w1c");
    $display("soft reset done");
  endtask
  task automatic t_hrst();
    dly <= 8'h0;
    ata_reset_n <= 1'h0;
    wt(3, 1'h1, BSY_CYC);
    chk(n <= BSY_CYC, 1, "hrst bsy");
    t = n + 10;
    repeat (10) @(posedge pclk);
    ata_reset_n <= 1'h1;
    wt(3, 1'h0, R);
    chk({t + n <= R + 4, rdy}, 2'h3, "hrst rdy");
    $display("hard reset done");
  endtask
  task automatic t_din();
    dly <= 8'h0A;
    apb(1'h1, OFS_INTMSK, 32'hF);
    issue(CAT_DIN);
    wt(1, 1'h1, C);
    @(posedge pclk);
    chk({n <= C, bsy, irq}, 3'h5, "din drq");
    nr = 0;
    repeat (WORDS) apb(1'h0, OFS_DATA, 32'h0);
    wt(3, 1'h1, DIN_CYC);
    chk({n <= DIN_CYC, drq}, 2'h2, "din bsy");
    @(posedge pclk);
    chk(nr, WORDS, "rd count");
    fin(1'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 0, "irq clr");
    $display("data in done");
  endtask
  task automatic t_dout();
    issue(CAT_DOUT);
    wt(1, 1'h1, C);
    nw = 0;
    repeat (WORDS) apb(1'h1, OFS_DATA, 32'h1234);
    wt(3, 1'h1, DOUT_CYC);
    chk({n <= DOUT_CYC, drq}, 2'h2, "dout bsy");
    @(posedge pclk);
    chk(nw, WORDS, "wr count");
    chk(be_wdata, 32'h1234, "wr data");
    fin(1'h1);
    $display("data out done");
  endtask
  task automatic t_nd();
    apb(1'h1, OFS_INTMSK, 32'h0);
    issue(CAT_ND);
    fin(1'h0);
    issue(CAT_DMA);
    fin(1'h0);
    $display("non-data done");
  endtask
  task automatic t_tmo();
    issue(CAT_ND);
    wt(3, 1'h0, C + 2);
    apb(1'h0, OFS_STAT, 32'h0);
    chk({n <= C + 2, rd[ERR_BIT]}, 2'h3, "tmo err");
    apb(1'h0, OFS_INTST, 32'h0);
    chk(rd[EV_TMO], 1, "tmo ev");
    t_srst(8'h28);
    issue(CAT_ND);
    fin(1'h0);
    apb(1'h0, OFS_STAT, 32'h0);
    chk(rd[ERR_BIT], 0, "err clr");
    $display("timeout done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    {psel, penable, pwrite, presetn, done_req} = 5'h0;
    {paddr, pwdata, dly} = 48'h0;
    ata_reset_n = 1'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_srst(8'h28);
    t_srst(8'h0);
    t_hrst();
    t_din();
    t_dout();
    t_nd();
    t_tmo();
    conclude();
  end
endmodule // atsm_bench
`default_nettype wire
